// ### bench/brs_stage_model.sv
// Behavioural power stage: output node, reference comparator and envelope
`timescale 1ns/1ns
`default_nettype none
module brs_stage_model #(
    parameter int STEP = 2
) (
    // Clock
    input  wire logic       pclk,
    // Switch drive and reference
    input  wire logic       high_side_on,
    input  wire logic       low_side_on,
    input  wire logic [7:0] ref_dac_level,
    // Envelope fault command
    input  wire logic       bad_win,
    // Comparators
    output logic            vout_below_ref,
    output logic            vout_in_window
);
    int v   = 0;
    int cyc = 0;
    int d;

    // --------------------------------
    // Output node
    // --------------------------------
    // no sink path: with both switches off the node only leaks away slowly
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (high_side_on)
            v <= v + STEP;
        else if (low_side_on)
            v <= v - STEP;
        else if (cyc % 16 == 0 && v > 0)
            v <= v - 1;
    end

    // --------------------------------
    // Comparators
    // --------------------------------
    // compare and window
    always_comb begin
        d              = v - 8 * int'(ref_dac_level);
        vout_below_ref = (d < 0);
        vout_in_window = !bad_win && d > -64 && d < 64;
    end
endmodule : brs_stage_model
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the reference sequencer core
`timescale 1ns/1ns
`default_nettype none
`include "brs_map.svh"
module testbench;
    import brs_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        en_pin, vin_above_input_undervoltage_lockout, vout_below_ref, vout_in_window, vout_undervolt;
    logic        overcurrent_trip, overtemp_event, light_load, bad_win;
    logic        high_side_on, low_side_on, pulse_skip_mode, low_emission_rise;
    logic        power_good_out, power_good_oe;
    logic [7:0]  ref_dac_level;
    logic [6:0]  code;
    logic [32:0] exp_q[$];
    logic [32:0] msk_q[$];
    int          mismatches = 0;
    int          tests_run  = 0;
    int          seed       = 99821;
    int          n;

    brs_top #(.HICCUP_CYC(50)) brs_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .en_pin(en_pin), .vin_above_input_undervoltage_lockout(vin_above_input_undervoltage_lockout), .vout_below_ref(vout_below_ref),
        .vout_in_window(vout_in_window), .vout_undervolt(vout_undervolt),
        .overcurrent_trip(overcurrent_trip), .overtemp_event(overtemp_event),
        .light_load(light_load), .high_side_on(high_side_on), .low_side_on(low_side_on),
        .ref_dac_level(ref_dac_level), .pulse_skip_mode(pulse_skip_mode),
        .low_emission_rise(low_emission_rise), .power_good_out(power_good_out),
        .power_good_oe(power_good_oe));

    brs_stage_model brs_stage_model_i (
        .pclk(pclk), .high_side_on(high_side_on), .low_side_on(low_side_on),
        .ref_dac_level(ref_dac_level), .bad_win(bad_win),
        .vout_below_ref(vout_below_ref), .vout_in_window(vout_in_window));

    // --------------------------------
    // Checking and verdict
    // --------------------------------
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out;
        if (mismatches == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    // Read results are matched against the oldest note
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0
            && exp_q.size() > 0) begin
            chk({pslverr, prdata} & msk_q[0], exp_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end

    // --------------------------------
    // Bus and wait tasks
    // --------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge pclk);
            k++;
        end
        if (k == 20)
            chk(pready, 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back({25'h0, e});
        msk_q.push_back({1'b1, 24'hFF_FFFF, m});
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic wait_lvl(input logic [7:0] t, output int c);
        logic [7:0] l0;
        l0 = ref_dac_level;
        c  = 0;
        while (ref_dac_level !== t && c < 40000) begin
            @(posedge pclk);
            c++;
            if (ref_dac_level !== 8'h00 && ref_dac_level !== l0 && ref_dac_level !== t) begin
                chk(pulse_skip_mode, 1'b1);
                chk(power_good_oe, 1'b1);
                if (light_load)
                    chk(low_side_on, 1'b0);
            end
        end
    endtask : wait_lvl

    // --------------------------------
    // Clock and watchdog
    // --------------------------------
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    initial begin
        repeat (90000) @(posedge pclk);
        mismatches++;
        close_out();
    end

    // --------------------------------
    // Main sequence
    // --------------------------------
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr  = 12'h000;
        pwdata = 32'h0000_0000;
        {en_pin, vin_above_input_undervoltage_lockout, vout_undervolt, overcurrent_trip} = 4'h0;
        {overtemp_event, light_load, bad_win} = 3'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(`BRS_ADDR_STATUS, 8'h00, 8'h07);
        rd(`BRS_ADDR_VOLTAGE_CODE_FIELD, 8'hC0, 8'hFF);
        rd(`BRS_ADDR_CTRL, 8'h06, 8'h1F);
        apb(1'b1, `BRS_ADDR_CTRL, 32'h0000_0010);
        rd(`BRS_ADDR_CTRL, 8'h10, 8'h1F);
        exp_q.push_back({1'b1, 32'h0});
        msk_q.push_back('1);
        apb(1'b0, 12'h010, 32'h0000_0000);
        @(posedge pclk) en_pin <= 1'b1;
        repeat (5) @(posedge pclk);
        rd(`BRS_ADDR_MON, 8'h00, 8'h70);
        @(posedge pclk) vin_above_input_undervoltage_lockout <= 1'b1;
        repeat (3) @(posedge pclk);
        rd(`BRS_ADDR_CTRL, 8'h06, 8'h1F);
        rd(`BRS_ADDR_MON, 8'h10, 8'h70);
        wait_lvl(8'hC0, n);
        chk(ref_dac_level, 8'hC0);
        chk(n >= 192 * 146 && n <= 192 * 146 + 500, 1'b1);
        repeat (100) @(posedge pclk);
        chk(power_good_oe, 1'b0);
        chk(power_good_out, 1'b0);
        rd(`BRS_ADDR_MON, 8'h31, 8'h73);
        n = 0;
        // Trip just after the upper switch turns on, so it is still on
        while (high_side_on !== 1'b0 && n < 1000) begin
            @(posedge pclk);
            n++;
        end
        while (high_side_on !== 1'b1 && n < 1000) begin
            @(posedge pclk);
            n++;
        end
        overcurrent_trip <= 1'b1;
        overtemp_event   <= 1'b1;
        @(posedge pclk);
        overcurrent_trip <= 1'b0;
        overtemp_event   <= 1'b0;
        repeat (9) begin
            @(posedge pclk);
            chk(high_side_on, 1'b0);
        end
        rd(`BRS_ADDR_STATUS, 8'h06, 8'h06);
        apb(1'b1, `BRS_ADDR_STATUS, 32'h0000_0004);
        rd(`BRS_ADDR_STATUS, 8'h02, 8'h06);
        apb(1'b1, `BRS_ADDR_STATUS, 32'h0000_0002);
        rd(`BRS_ADDR_STATUS, 8'h00, 8'h06);
        code = 7'h30 + 7'($random(seed) & 7);
        @(posedge pclk) light_load <= 1'b1;
        apb(1'b1, `BRS_ADDR_VOLTAGE_CODE_FIELD, {24'h0, 1'b1, code});
        apb(1'b1, `BRS_ADDR_CTRL, 32'h0000_0001);
        wait_lvl({1'b1, code}, n);
        chk(ref_dac_level, {1'b1, code});
        chk(n >= int'(7'h40 - code) * 73 - 73 && n <= int'(7'h40 - code) * 73 + 80, 1'b1);
        @(posedge pclk) light_load <= 1'b0;
        repeat (5) @(posedge pclk);
        chk(pulse_skip_mode, 1'b0);
        rd(`BRS_ADDR_CTRL, 8'h00, 8'h1F);
        apb(1'b1, `BRS_ADDR_CTRL, 32'h0000_0012);
        repeat (300) @(posedge pclk);
        chk(low_emission_rise, 1'b1);
        chk(pulse_skip_mode, 1'b1);
        chk(power_good_oe, 1'b0);
        @(posedge pclk) bad_win <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(power_good_oe, 1'b1);
        rd(`BRS_ADDR_MON, 8'h30, 8'h73);
        @(posedge pclk) begin
            bad_win        <= 1'b0;
            vout_undervolt <= 1'b1;
        end
        repeat (3) @(posedge pclk);
        chk({high_side_on, low_side_on}, 2'b00);
        rd(`BRS_ADDR_MON, 8'h40, 8'h70);
        repeat (60) @(posedge pclk);
        rd(`BRS_ADDR_MON, 8'h10, 8'h70);
        repeat (300) @(posedge pclk);
        rd(`BRS_ADDR_MON, 8'h20, 8'h70);
        rd(`BRS_ADDR_STATUS, 8'h01, 8'h01);
        @(posedge pclk) vout_undervolt <= 1'b0;
        apb(1'b1, `BRS_ADDR_VOLTAGE_CODE_FIELD, 32'h0000_0040);
        repeat (3) @(posedge pclk);
        chk({high_side_on, low_side_on}, 2'b00);
        rd(`BRS_ADDR_MON, 8'h00, 8'h70);
        rd(`BRS_ADDR_VOLTAGE_CODE_FIELD, 8'h40, 8'hFF);
        close_out();
    end
endmodule : testbench
`default_nettype wire

// ### hw/brs_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef BRS_MAP_SVH
`define BRS_MAP_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define BRS_CLK_NS         40

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define BRS_ADDR_STATUS    12'h000
`define BRS_ADDR_VOLTAGE_CODE_FIELD      12'h004
`define BRS_ADDR_CTRL      12'h008
`define BRS_ADDR_MON       12'h00C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BRS_ST_OCP         2
`define BRS_ST_OTP         1
`define BRS_ST_FBUV        0
`define BRS_VS_EN          7
`define BRS_CT_GO          0
`define BRS_CT_PSM         1
`define BRS_CT_SLEW        2
`define BRS_CT_LOWEM       4
`define BRS_MON_POWER_GOOD_MONITOR_BIT       0
`define BRS_MON_RAMP       1
`define BRS_MON_STATE      4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BRS_CODE_HI        7'h40
`define BRS_CODE_LO        7'h2B
`define BRS_CTRL_RST       5'h06
`define BRS_STATUS_RST     3'h0
`define BRS_LEVEL_OFS      8'h80

// ----------------------------------------
// Times and derived cycle counts
// ----------------------------------------
`define BRS_OCP_BLANK_NS   350
`define BRS_OCP_CYC        ((`BRS_OCP_BLANK_NS + `BRS_CLK_NS - 1) / `BRS_CLK_NS)
`define BRS_HICCUP_NS      1500000
`define BRS_HICCUP_CYC     (`BRS_HICCUP_NS / `BRS_CLK_NS)
`define BRS_BIAS_NS        10000
`define BRS_BIAS_CYC       ((`BRS_BIAS_NS + `BRS_CLK_NS - 1) / `BRS_CLK_NS)
`define BRS_SLEW0_NS       2930
`define BRS_SLEW1_NS       5859
`define BRS_SLEW2_NS       11719
`define BRS_SLEW3_NS       23438
`define BRS_SLEW0_CYC      (`BRS_SLEW0_NS / `BRS_CLK_NS)
`define BRS_SLEW1_CYC      (`BRS_SLEW1_NS / `BRS_CLK_NS)
`define BRS_SLEW2_CYC      (`BRS_SLEW2_NS / `BRS_CLK_NS)
`define BRS_SLEW3_CYC      (`BRS_SLEW3_NS / `BRS_CLK_NS)

`endif

// ### hw/brs_pkg.sv
// Types shared by the reference sequencer modules
package brs_pkg;
    typedef enum logic [2:0] {
        BRS_OFF     = 3'b000,
        BRS_BIAS    = 3'b001,
        BRS_SOFT    = 3'b010,
        BRS_RUN     = 3'b011,
        BRS_HICCUP  = 3'b100
    } brs_state_t;

    typedef enum logic [1:0] {
        BRS_SLEW_FAST  = 2'b00,
        BRS_SLEW_DEF   = 2'b01,
        BRS_SLEW_SLOW  = 2'b10,
        BRS_SLEW_LEAST = 2'b11
    } brs_slew_t;
endpackage : brs_pkg

// ### hw/brs_ramp.sv
// Reference ramp: steps the DAC level one LSB per slew interval
`timescale 1ns/1ns
`default_nettype none
`include "brs_map.svh"
module brs_ramp (
    // Clock and reset
    input wire logic  pclk,
    input wire logic  presetn,
    // Sequencer side
    brs_ramp_if.rmp   rif
);
    import brs_pkg::*;

    logic [7:0]  level_q;
    logic [7:0]  level_d;
    logic [7:0]  tgt_q;
    logic [7:0]  tgt_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;

    function automatic logic [15:0] slew_cycles(input brs_slew_t s);
        case (s)
            BRS_SLEW_FAST:  slew_cycles = 16'(`BRS_SLEW0_CYC);
            BRS_SLEW_DEF:   slew_cycles = 16'(`BRS_SLEW1_CYC);
            BRS_SLEW_SLOW:  slew_cycles = 16'(`BRS_SLEW2_CYC);
            default:        slew_cycles = 16'(`BRS_SLEW3_CYC);
        endcase
    endfunction : slew_cycles

    wire         moving = (level_q != tgt_q);
    wire         tick   = (cnt_q >= slew_cycles(rif.slew_sel) - 16'h0001);
    wire [7:0]   step   = (level_q < tgt_q) ? level_q + 8'h01 : level_q - 8'h01;

    // R22: one LSB per slew interval
    assign cnt_d   = rif.clear ? 16'h0000 : ((!moving || tick) ? 16'h0000 : cnt_q + 16'h0001);
    assign level_d = rif.clear ? 8'h00 : ((moving && tick) ? step : level_q);
    assign tgt_d   = rif.clear ? 8'h00 : (rif.start ? rif.target : tgt_q);

    assign rif.level = level_q;
    assign rif.busy  = moving;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q <= 8'h00;
            tgt_q   <= 8'h00;
            cnt_q   <= 16'h0000;
        end else begin
            level_q <= level_d;
            tgt_q   <= tgt_d;
            cnt_q   <= cnt_d;
        end
    end
endmodule : brs_ramp
`default_nettype wire

// ### hw/brs_ramp_if.sv
// Control and status signals between sequencer and reference ramp
`timescale 1ns/1ns
`default_nettype none
interface brs_ramp_if;
    logic               clear;
    logic               start;
    logic [7:0]         target;
    brs_pkg::brs_slew_t slew_sel;
    logic [7:0]         level;
    logic               busy;

    modport ctl (output clear, output start, output target, output slew_sel,
                 input level, input busy);
    modport rmp (input clear, input start, input target, input slew_sel,
                 output level, output busy);
endinterface : brs_ramp_if
`default_nettype wire

// ### hw/brs_top.sv
// Sequencer core of the hysteretic step-down regulator with APB registers
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "brs_map.svh"
//
// Contract
// R1: reference equals 0.6 V plus code steps
// R2: default code at startup per variant
// R3: start only when enabled and supply good
// R4: startup reloads every register with defaults
// R5: after bias settle ramp from zero
// R6: power good low until ramp done
// R7: ramps force pulse-skip operation
// R8: overcurrent blanks upper switch 350 ns
// R9: undervoltage hiccups 1.5 ms, then restart
// R10: undervoltage ignored during startup
// R11: write code, then go starts ramp
// R12: monitor bit low during ramp, envelope
// R13: no sinking on downward skip transitions
// R14: enable from pin and register bit
// R15: registers stay accessible while disabled
// R16: low emission slows switch rise
// R17: below reference upper on, else lower
// R18: skip mode lets light load go discontinuous
// R19: software selects skip mode and slew
// R20: sticky fault flags, write one clears
// R21: write data commits only at completion
// R22: ramp steps one LSB per interval
// R23: blanking and hiccup counters reset on disable
module brs_top #(
    parameter logic [6:0]  DEFAULT_CODE = `BRS_CODE_HI,
    parameter int unsigned HICCUP_CYC   = `BRS_HICCUP_CYC
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Control pin and analog comparators
    input  wire logic        en_pin,
    input  wire logic        vin_above_input_undervoltage_lockout,
    input  wire logic        vout_below_ref,
    input  wire logic        vout_in_window,
    input  wire logic        vout_undervolt,
    input  wire logic        overcurrent_trip,
    input  wire logic        overtemp_event,
    input  wire logic        light_load,
    // Power stage drive
    output logic             high_side_on,
    output logic             low_side_on,
    output logic      [7:0]  ref_dac_level,
    output logic             pulse_skip_mode,
    output logic             low_emission_rise,
    // Open-drain power good
    output logic             power_good_out,
    output logic             power_good_oe
);
    import brs_pkg::*;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    brs_state_t  state_q;
    brs_state_t  state_d;
    logic [2:0]  status_q;
    logic [2:0]  status_d;
    logic [7:0]  voltage_code_field_q;
    logic [7:0]  voltage_code_field_d;
    logic [4:0]  ctrl_q;
    logic [4:0]  ctrl_d;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [3:0]  blank_q;
    logic [3:0]  blank_d;
    logic [31:0] wait_q;
    logic [31:0] wait_d;
    logic        hs_q;
    logic        ls_q;
    logic        skip_q;
    logic        lowem_q;
    logic        pg_q;
    logic [7:0]  dac_q;

    brs_ramp_if rif ();

    brs_ramp u_ramp (
        .pclk    (pclk),
        .presetn (presetn),
        .rif     (rif)
    );

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire setup_ph  = psel && !penable;
    wire wr_commit = psel && penable && pready_q && pwrite;
    wire hit_stat  = (paddr == `BRS_ADDR_STATUS);
    wire hit_voltage_code_field  = (paddr == `BRS_ADDR_VOLTAGE_CODE_FIELD);
    wire hit_ctrl  = (paddr == `BRS_ADDR_CTRL);
    wire hit_mon   = (paddr == `BRS_ADDR_MON);
    wire mapped    = hit_stat || hit_voltage_code_field || hit_ctrl || hit_mon;
    // R21: only a completed access writes
    wire wr_stat   = wr_commit && hit_stat;
    wire wr_voltage_code_field   = wr_commit && hit_voltage_code_field;
    wire wr_ctrl   = wr_commit && hit_ctrl;

    // ----------------------------------------
    // Enable and sequencing conditions
    // ----------------------------------------
    // R14: pin and register bit both enable
    wire enabled    = en_pin && voltage_code_field_q[`BRS_VS_EN];
    // R3: supply above lockout and enabled
    wire start_ok   = enabled && vin_above_input_undervoltage_lockout;
    wire start_seq  = (state_q == BRS_OFF) && start_ok;
    wire go_pulse   = wr_ctrl && pwdata[`BRS_CT_GO];
    // R1: level counts LSBs from 0 V, 0.6 V is the offset
    wire [7:0] tgt  = `BRS_LEVEL_OFS + {1'b0, voltage_code_field_q[6:0]};
    wire bias_done  = (wait_q >= 32'(`BRS_BIAS_CYC) - 32'h0000_0001);
    wire hic_done   = (wait_q >= HICCUP_CYC - 32'h0000_0001);
    // R10: undervoltage acts only in run state
    wire uv_fault   = (state_q == BRS_RUN) && vout_undervolt;
    wire soft_done  = (state_q == BRS_SOFT) && !rif.busy && (rif.level == tgt);
    wire switching  = (state_q == BRS_SOFT) || (state_q == BRS_RUN);
    // R7: ramp forces skip mode
    wire skip_now   = ctrl_q[`BRS_CT_PSM] || rif.busy;

    // ----------------------------------------
    // State machine
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            BRS_OFF: begin
                if (start_ok) begin
                    state_d = BRS_BIAS;
                end
            end
            BRS_BIAS: begin
                if (bias_done) begin
                    state_d = BRS_SOFT;
                end
            end
            BRS_SOFT: begin
                if (soft_done) begin
                    state_d = BRS_RUN;
                end
            end
            BRS_RUN: begin
                // R9: undervoltage enters hiccup
                if (uv_fault) begin
                    state_d = BRS_HICCUP;
                end
            end
            BRS_HICCUP: begin
                // R9: restart complete soft start
                if (hic_done) begin
                    state_d = BRS_BIAS;
                end
            end
            default: begin
                state_d = BRS_OFF;
            end
        endcase
        if (!start_ok && state_q != BRS_OFF) begin
            state_d = BRS_OFF;
        end
    end

    // R23: shared wait counter cleared when disabled
    assign wait_d = (state_d != state_q || state_q == BRS_OFF) ? 32'h0000_0000
                                                               : wait_q + 32'h0000_0001;

    // ----------------------------------------
    // Ramp control
    // ----------------------------------------
    // R5: ramp starts from zero after bias
    assign rif.clear    = (state_q == BRS_OFF) || (state_q == BRS_HICCUP) || !start_ok;
    // R11: go launches ramp to programmed code
    assign rif.start    = (state_q == BRS_BIAS && bias_done) || (state_q == BRS_RUN && go_pulse);
    assign rif.target   = tgt;
    // R19: slew selected by software
    assign rif.slew_sel = brs_slew_t'(ctrl_q[`BRS_CT_SLEW +: 2]);

    // ----------------------------------------
    // Register next values
    // ----------------------------------------
    wire [2:0] st_events = {overcurrent_trip && switching, overtemp_event, uv_fault};
    wire [2:0] st_w1c    = wr_stat ? pwdata[2:0] : 3'h0;

    always_comb begin
        // R20: set wins over write-one clear
        status_d = (status_q & ~st_w1c) | st_events;
        voltage_code_field_d   = wr_voltage_code_field ? pwdata[7:0] : voltage_code_field_q;
        ctrl_d   = wr_ctrl ? {pwdata[4:1], 1'b0} : ctrl_q;
        // R4: each new startup reloads defaults
        if (start_seq) begin
            status_d = `BRS_STATUS_RST;
            // R2: variant default code
            voltage_code_field_d   = {1'b1, DEFAULT_CODE};
            ctrl_d   = `BRS_CTRL_RST;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    wire [31:0] rd_mux =
        hit_stat ? {29'h0, status_q} :
        hit_voltage_code_field ? {24'h0, voltage_code_field_q} :
        hit_ctrl ? {27'h0, ctrl_q} :
        hit_mon  ? {25'h0, state_q, 2'b00, rif.busy, pg_q} : 32'h0000_0000;

    // ----------------------------------------
    // Switch drive
    // ----------------------------------------
    // R8: overcurrent loads blanking count
    assign blank_d = !start_ok ? 4'h0 :
                     (overcurrent_trip && hs_q) ? 4'(`BRS_OCP_CYC) :
                     (blank_q != 4'h0) ? blank_q - 4'h1 : 4'h0;

    // R17: hysteretic choice of switch
    wire hs_d = switching && vout_below_ref && !overcurrent_trip && (blank_q == 4'h0);
    // R13: no sinking in skip on light load
    // R18: skip lets light load go discontinuous
    wire ls_d = switching && !vout_below_ref && !(skip_now && light_load);
    // R6: power good waits for finished ramp
    // R12: monitor low during ramp or outside envelope
    wire pg_d = (state_q == BRS_RUN) && !rif.busy && vout_in_window;

    // ----------------------------------------
    // Flip-flops
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= BRS_OFF;
            wait_q   <= 32'h0000_0000;
            status_q <= `BRS_STATUS_RST;
            voltage_code_field_q   <= {1'b1, DEFAULT_CODE};
            ctrl_q   <= `BRS_CTRL_RST;
        end else begin
            state_q  <= state_d;
            wait_q   <= wait_d;
            status_q <= status_d;
            voltage_code_field_q   <= voltage_code_field_d;
            ctrl_q   <= ctrl_d;
        end
    end

    // R15: bus answers whatever the enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= setup_ph ? rd_mux : prdata_q;
            pready_q  <= setup_ph;
            pslverr_q <= setup_ph && !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blank_q <= 4'h0;
            hs_q    <= 1'b0;
            ls_q    <= 1'b0;
            skip_q  <= 1'b0;
            lowem_q <= 1'b0;
            pg_q    <= 1'b0;
            dac_q   <= 8'h00;
        end else begin
            blank_q <= blank_d;
            hs_q    <= hs_d;
            ls_q    <= ls_d;
            skip_q  <= skip_now;
            // R16: low emission slows rise 25 percent
            lowem_q <= ctrl_q[`BRS_CT_LOWEM];
            pg_q    <= pg_d;
            dac_q   <= rif.level;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata            = prdata_q;
    assign pready            = pready_q;
    assign pslverr           = pslverr_q;
    assign high_side_on      = hs_q;
    assign low_side_on       = ls_q;
    assign ref_dac_level     = dac_q;
    assign pulse_skip_mode   = skip_q;
    assign low_emission_rise = lowem_q;
    assign power_good_out    = 1'b0;
    assign power_good_oe     = !pg_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ocp_blank; // R8
        overcurrent_trip && hs_q && start_ok |=> !hs_q [*8];
    endproperty
    a_ocp_blank: assert property (p_ocp_blank) else $error("upper switch back on too soon");

    property p_ramp_skip; // R7
        rif.busy |=> skip_q;
    endproperty
    a_ramp_skip: assert property (p_ramp_skip) else $error("skip not forced during ramp");

    property p_pg_ramp; // R6
        rif.busy |=> !pg_q && power_good_oe;
    endproperty
    a_pg_ramp: assert property (p_pg_ramp) else $error("power good during ramp");

    property p_hiccup; // R9
        uv_fault && start_ok |=> state_q == BRS_HICCUP ##1 (!hs_q && !ls_q) [*8];
    endproperty
    a_hiccup: assert property (p_hiccup) else $error("hiccup did not stop switching");

    property p_soft_no_uv; // R10
        state_q == BRS_SOFT |=> state_q != BRS_HICCUP;
    endproperty
    a_soft_no_uv: assert property (p_soft_no_uv) else $error("hiccup during startup");

    property p_hyst; // R17
        state_q == BRS_RUN && start_ok && vout_below_ref && !overcurrent_trip
            && blank_q == 4'h0 |=> hs_q && !ls_q;
    endproperty
    a_hyst: assert property (p_hyst) else $error("upper switch not on below reference");

    property p_flag_set; // R20
        overcurrent_trip && switching && !start_seq |=> status_q[`BRS_ST_OCP];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("overcurrent flag not latched");

    property p_disable; // R14
        !en_pin |=> state_q == BRS_OFF ##1 !hs_q;
    endproperty
    a_disable: assert property (p_disable) else $error("not off after pin disable");

    property p_start_gate; // R3
        state_q == BRS_OFF && !vin_above_input_undervoltage_lockout |=> state_q == BRS_OFF;
    endproperty
    a_start_gate: assert property (p_start_gate) else $error("started below lockout");

    property p_defaults; // R4
        state_q == BRS_BIAS && $past(state_q) == BRS_OFF |-> voltage_code_field_q == {1'b1, DEFAULT_CODE};
    endproperty
    a_defaults: assert property (p_defaults) else $error("code not reloaded at startup");
endmodule : brs_top
`default_nettype wire
